// ---- serial_isp_command_engine.sv ----
// Purpose: serial in-system programming engine for flash, eeprom, fuses and lock
// Assumes: core clock well above serial clock; isp_reset_n held low for the session
// Notes: memories are modelled as arrays; wait counts are parameters
//
// Function
// - mosi is sampled on each rising edge of the serial clock.
// - miso bits are shifted out on each falling edge of the serial clock.
// - enable is AC 53 00 00; 53 echoes while the third byte shifts.
// - out of sync, no programming instruction is carried out.
// - 40/48 load low/high page buffer bytes at word address b3[5:0].
// - 4C commits the page buffer to the flash page in address MSBs.
// - C0 erases then writes one eeprom byte; busy lasts 3.6 ms.
// - C1 loads eeprom page bytes, C2 commits only loaded bytes.
// - chip erase AC 80 sets flash and eeprom to erased, busy 10.5 ms.
// - poll F0 returns pending flag in bit 0 of byte four.
// - reads 20/28/A0 return flash low/high or eeprom in byte four.
// - fuse and lock reads return their byte in byte four.
// - AC A0/A8/A4 write low, high, extended fuse; busy 4.5 ms.
// - fuse bits 0 mean programmed; AC E0 writes the lock byte.
// - 4D captures an extended address byte from byte three.
// - program memory uses word addresses, words loaded in any order.
// - reset pin high leaves programming mode and resumes normal operation.
// - programming is active while reset pin low; enable must come first.
`timescale 1ns/1ns
module serial_isp_command_engine #(
	parameter int FLASH_WAIT_CYCLES = isp_pkg::WD_FLASH_CYCLES,
	parameter int EEPROM_WAIT_CYCLES = isp_pkg::WD_EEPROM_CYCLES,
	parameter int ERASE_WAIT_CYCLES = isp_pkg::WD_ERASE_CYCLES,
	parameter int FUSE_WAIT_CYCLES = isp_pkg::WD_FUSE_CYCLES
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// programming pins
	input wire logic isp_reset_n,
	input wire logic sck,
	input wire logic mosi,
	output logic miso,
	// status
	output logic prog_active,
	output logic prog_enabled,
	output logic operation_pending_flag,
	output logic core_run,
	output logic [7:0] ext_address
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic prog_mode;
		logic enabled;
		logic [4:0] bit_cnt;
		logic [31:0] rx;
		logic [7:0] tx;
		logic miso;
		logic sck_d;
		logic [7:0] ext_addr;
		logic erasing;
		logic [isp_pkg::FLASH_AW-1:0] erase_addr;
		logic [7:0] fuse_lo;
		logic [7:0] fuse_hi;
		logic [7:0] fuse_ext;
		logic [7:0] lock;
		logic [3:0] ee_mask;
		logic [3:0][7:0] ee_buf;
		logic pending;
		logic run;
	} state_t;

	localparam state_t ST_RESET = '{
		prog_mode: 1'b0, enabled: 1'b0, bit_cnt: '0, rx: '0, tx: '0,
		miso: 1'b0, sck_d: 1'b0, ext_addr: '0, erasing: 1'b0, erase_addr: '0,
		fuse_lo: isp_pkg::FUSE_LO_RST, fuse_hi: isp_pkg::FUSE_HI_RST,
		fuse_ext: isp_pkg::FUSE_EXT_RST, lock: isp_pkg::LOCK_RST,
		ee_mask: '0, ee_buf: '0, pending: 1'b0, run: 1'b1
	};

	state_t st_r;
	state_t st_nxt;

	// ----------------------------------------
	// memories
	// ----------------------------------------
	logic [15:0] flash_mem [0:(1<<isp_pkg::FLASH_AW)-1];
	logic [7:0] ee_mem [0:(1<<isp_pkg::EE_AW)-1];
	logic [15:0] page_buf [0:(1<<isp_pkg::PAGE_AW)-1];

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [2:0] pins_s;
	logic rst_s;
	logic sck_s;
	logic mosi_s;

	pin_sync #(.W(3), .INIT(3'h4)) pin_sync_i (
		.clock(clock),
		.reset_n(reset_n),
		.pin_in({isp_reset_n, sck, mosi}),
		.pin_out(pins_s)
	);

	assign rst_s = pins_s[2];
	assign sck_s = pins_s[1];
	assign mosi_s = pins_s[0];

	// ----------------------------------------
	// wait timer
	// ----------------------------------------
	logic tmr_start;
	logic [isp_pkg::TIMER_W-1:0] tmr_cycles;
	logic tmr_busy;

	op_timer op_timer_i (
		.clock(clock),
		.reset_n(reset_n),
		.start(tmr_start),
		.cycles(tmr_cycles),
		.busy(tmr_busy)
	);

	// ----------------------------------------
	// decode and next state
	// ----------------------------------------
	logic rise;
	logic fall;
	logic [31:0] rx_nxt;
	logic [7:0] b1;
	logic [7:0] b2;
	logic [7:0] b3;
	logic [7:0] b4;
	logic [7:0] rd_data;
	logic frame_done;
	logic busy;
	logic pg_load_lo;
	logic pg_load_hi;
	logic pg_commit;
	logic ee_byte_wr;
	logic ee_page_wr;
	logic [isp_pkg::FLASH_AW-1:0] fl_addr;
	logic [isp_pkg::EE_AW-1:0] ee_addr;

	always_comb begin
		st_nxt = st_r;
		rise = sck_s & ~st_r.sck_d;
		fall = ~sck_s & st_r.sck_d;
		rx_nxt = {st_r.rx[30:0], mosi_s};
		b1 = rx_nxt[31:24];
		b2 = rx_nxt[23:16];
		b3 = rx_nxt[15:8];
		b4 = rx_nxt[7:0];
		fl_addr = {rx_nxt[12:8], rx_nxt[7:0]};
		ee_addr = {rx_nxt[8], rx_nxt[7:0]};
		busy = tmr_busy | st_r.erasing;
		frame_done = 1'b0;
		tmr_start = 1'b0;
		tmr_cycles = '0;
		pg_load_lo = 1'b0;
		pg_load_hi = 1'b0;
		pg_commit = 1'b0;
		ee_byte_wr = 1'b0;
		ee_page_wr = 1'b0;
		rd_data = 8'h00;
		st_nxt.sck_d = sck_s;
		st_nxt.pending = busy;

		// byte four answers, from the first three bytes in rx_nxt[23:0]
		if (st_r.enabled) begin
			case (rx_nxt[23:16])
				isp_pkg::OP_POLL: rd_data = {7'h00, busy};
				isp_pkg::OP_RD_LO: rd_data = flash_mem[fl_addr][7:0];
				isp_pkg::OP_RD_HI: rd_data = flash_mem[fl_addr][15:8];
				isp_pkg::OP_EE_RD: rd_data = ee_mem[ee_addr];
				isp_pkg::OP_RD_FUSE: begin
					if (rx_nxt[15:8] == isp_pkg::SUB_RD_HIGH) begin
						rd_data = st_r.fuse_ext;
					end else begin
						rd_data = st_r.fuse_lo;
					end
				end
				isp_pkg::OP_RD_LOCK: begin
					if (rx_nxt[15:8] == isp_pkg::SUB_RD_HIGH) begin
						rd_data = st_r.fuse_hi;
					end else begin
						rd_data = st_r.lock;
					end
				end
				isp_pkg::OP_RD_SIG: begin
					case (rx_nxt[1:0])
						2'h0: rd_data = isp_pkg::SIG_BYTE0;
						2'h1: rd_data = isp_pkg::SIG_BYTE1;
						default: rd_data = isp_pkg::SIG_BYTE2;
					endcase
				end
				isp_pkg::OP_RD_CAL: rd_data = isp_pkg::CAL_BYTE;
				default: rd_data = 8'h00;
			endcase
		end

		if (!rst_s) begin
			st_nxt.prog_mode = 1'b1;
			if (rise) begin
				st_nxt.rx = rx_nxt;
				st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
				if (st_r.bit_cnt[2:0] == isp_pkg::BIT_BYTE_END) begin
					if (st_r.bit_cnt == isp_pkg::BIT_BYTE3_END) begin
						st_nxt.tx = rd_data;
					end else begin
						st_nxt.tx = rx_nxt[7:0];
					end
				end
				frame_done = (st_r.bit_cnt == isp_pkg::BIT_LAST);
			end else if (fall) begin
				st_nxt.miso = st_r.tx[7];
				st_nxt.tx = {st_r.tx[6:0], 1'b0};
			end
		end else begin
			// leaving the session drops sync and framing
			st_nxt.prog_mode = 1'b0;
			st_nxt.enabled = 1'b0;
			st_nxt.bit_cnt = '0;
			st_nxt.tx = '0;
			st_nxt.miso = 1'b0;
			st_nxt.ee_mask = '0;
		end

		if (frame_done) begin
			if (b1 == isp_pkg::OP_PREFIX && b2 == isp_pkg::SUB_ENABLE) begin
				st_nxt.enabled = 1'b1;
			end else if (st_r.enabled && !busy) begin
				case (b1)
					isp_pkg::OP_PREFIX: begin
						case (b2)
							isp_pkg::SUB_ERASE: begin
								st_nxt.erasing = 1'b1;
								st_nxt.erase_addr = '0;
								st_nxt.lock = isp_pkg::LOCK_RST;
								st_nxt.ee_mask = '0;
								tmr_start = 1'b1;
								tmr_cycles = isp_pkg::TIMER_W'(ERASE_WAIT_CYCLES);
							end
							isp_pkg::SUB_FUSE_LO: begin
								st_nxt.fuse_lo = b4;
								tmr_start = 1'b1;
								tmr_cycles = isp_pkg::TIMER_W'(FUSE_WAIT_CYCLES);
							end
							isp_pkg::SUB_FUSE_HI: begin
								st_nxt.fuse_hi = b4;
								tmr_start = 1'b1;
								tmr_cycles = isp_pkg::TIMER_W'(FUSE_WAIT_CYCLES);
							end
							isp_pkg::SUB_FUSE_EXT: begin
								st_nxt.fuse_ext = b4;
								tmr_start = 1'b1;
								tmr_cycles = isp_pkg::TIMER_W'(FUSE_WAIT_CYCLES);
							end
							isp_pkg::SUB_LOCK: begin
								// lock bits only go to programmed; erase sets them back to unprogrammed
								st_nxt.lock = st_r.lock & b4;
								tmr_start = 1'b1;
								tmr_cycles = isp_pkg::TIMER_W'(FUSE_WAIT_CYCLES);
							end
							default: st_nxt.lock = st_r.lock;
						endcase
					end
					isp_pkg::OP_LOAD_EXT: st_nxt.ext_addr = b3;
					isp_pkg::OP_LOAD_LO: pg_load_lo = 1'b1;
					isp_pkg::OP_LOAD_HI: pg_load_hi = 1'b1;
					isp_pkg::OP_WR_PAGE: begin
						pg_commit = 1'b1;
						tmr_start = 1'b1;
						tmr_cycles = isp_pkg::TIMER_W'(FLASH_WAIT_CYCLES);
					end
					isp_pkg::OP_EE_WR: begin
						ee_byte_wr = 1'b1;
						tmr_start = 1'b1;
						tmr_cycles = isp_pkg::TIMER_W'(EEPROM_WAIT_CYCLES);
					end
					isp_pkg::OP_EE_LOAD: begin
						st_nxt.ee_buf[b3[1:0]] = b4;
						st_nxt.ee_mask[b3[1:0]] = 1'b1;
					end
					isp_pkg::OP_EE_PAGE: begin
						ee_page_wr = 1'b1;
						st_nxt.ee_mask = '0;
						tmr_start = 1'b1;
						tmr_cycles = isp_pkg::TIMER_W'(EEPROM_WAIT_CYCLES);
					end
					default: st_nxt.ext_addr = st_r.ext_addr;
				endcase
			end
		end

		// erase walks every address, one per clock, and holds busy until the walk ends even after the timer
		if (st_r.erasing) begin
			st_nxt.erase_addr = st_r.erase_addr + 1'b1;
			if (st_r.erase_addr == '1) begin
				st_nxt.erasing = 1'b0;
			end
		end
		st_nxt.run = ~st_nxt.prog_mode;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= ST_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// memory writes
	// ----------------------------------------
	logic [isp_pkg::FLASH_AW-1:0] pg_base;
	logic [isp_pkg::EE_AW-1:0] ee_base;

	assign pg_base = {b2[4:0], b3[7:isp_pkg::PAGE_AW], {isp_pkg::PAGE_AW{1'b0}}};
	assign ee_base = {b2[0], b3[7:isp_pkg::EE_PAGE_AW], {isp_pkg::EE_PAGE_AW{1'b0}}};

	always_ff @(posedge clock) begin
		if (pg_load_lo) begin
			page_buf[b3[isp_pkg::PAGE_AW-1:0]][7:0] <= b4;
		end
		if (pg_load_hi) begin
			page_buf[b3[isp_pkg::PAGE_AW-1:0]][15:8] <= b4;
		end
		if (pg_commit) begin
			for (int i = 0; i < (1 << isp_pkg::PAGE_AW); i++) begin
				flash_mem[pg_base | isp_pkg::FLASH_AW'(i)] <= page_buf[i];
				page_buf[i] <= isp_pkg::ERASED_WORD;
			end
		end
		if (ee_byte_wr) begin
			// self-timed erase then write lands as the new byte
			ee_mem[{b2[0], b3}] <= b4;
		end
		if (ee_page_wr) begin
			for (int j = 0; j < (1 << isp_pkg::EE_PAGE_AW); j++) begin
				if (st_r.ee_mask[j]) begin
					ee_mem[ee_base | isp_pkg::EE_AW'(j)] <= st_r.ee_buf[j];
				end
			end
		end
		if (st_r.erasing) begin
			flash_mem[st_r.erase_addr] <= isp_pkg::ERASED_WORD;
			ee_mem[st_r.erase_addr[isp_pkg::EE_AW-1:0]] <= isp_pkg::ERASED_BYTE;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign miso = st_r.miso;
	assign prog_active = st_r.prog_mode;
	assign prog_enabled = st_r.enabled;
	assign operation_pending_flag = st_r.pending;
	assign core_run = st_r.run;
	assign ext_address = st_r.ext_addr;

endmodule

// ---- isp_pkg.sv ----
// Purpose: shared constants of the serial programming engine
// Assumes: core clock of 10 MHz
// Notes: times are kept in microseconds, counts are derived from them
package isp_pkg;

	// ----------------------------------------
	// clock and wait times
	// ----------------------------------------
	localparam int CLOCK_HZ = 10000000;
	localparam int T_WD_FLASH_US = 2600;
	localparam int T_WD_EEPROM_US = 3600;
	localparam int T_WD_ERASE_US = 10500;
	localparam int T_WD_FUSE_US = 4500;
	localparam int WD_FLASH_CYCLES = T_WD_FLASH_US * (CLOCK_HZ / 1000000);
	localparam int WD_EEPROM_CYCLES = T_WD_EEPROM_US * (CLOCK_HZ / 1000000);
	localparam int WD_ERASE_CYCLES = T_WD_ERASE_US * (CLOCK_HZ / 1000000);
	localparam int WD_FUSE_CYCLES = T_WD_FUSE_US * (CLOCK_HZ / 1000000);
	localparam int TIMER_W = 17;

	// ----------------------------------------
	// memory geometry and frame bit counts
	// ----------------------------------------
	localparam int FLASH_AW = 13;
	localparam int PAGE_AW = 6;
	localparam int EE_AW = 9;
	localparam int EE_PAGE_AW = 2;
	localparam int FRAME_BITS = 32;
	localparam logic [4:0] BIT_LAST = 5'h1f;
	localparam logic [4:0] BIT_BYTE3_END = 5'h17;
	localparam logic [2:0] BIT_BYTE_END = 3'h7;

	// ----------------------------------------
	// opcodes (first byte) and sub codes (second byte)
	// ----------------------------------------
	localparam logic [7:0] OP_PREFIX = 8'hac;
	localparam logic [7:0] SUB_ENABLE = 8'h53;
	localparam logic [7:0] SUB_ERASE = 8'h80;
	localparam logic [7:0] SUB_FUSE_LO = 8'ha0;
	localparam logic [7:0] SUB_FUSE_HI = 8'ha8;
	localparam logic [7:0] SUB_FUSE_EXT = 8'ha4;
	localparam logic [7:0] SUB_LOCK = 8'he0;
	localparam logic [7:0] OP_POLL = 8'hf0;
	localparam logic [7:0] OP_LOAD_EXT = 8'h4d;
	localparam logic [7:0] OP_LOAD_HI = 8'h48;
	localparam logic [7:0] OP_LOAD_LO = 8'h40;
	localparam logic [7:0] OP_EE_LOAD = 8'hc1;
	localparam logic [7:0] OP_RD_HI = 8'h28;
	localparam logic [7:0] OP_RD_LO = 8'h20;
	localparam logic [7:0] OP_EE_RD = 8'ha0;
	localparam logic [7:0] OP_RD_LOCK = 8'h58;
	localparam logic [7:0] OP_RD_FUSE = 8'h50;
	localparam logic [7:0] SUB_RD_HIGH = 8'h08;
	localparam logic [7:0] SUB_RD_PLAIN = 8'h00;
	localparam logic [7:0] OP_RD_SIG = 8'h30;
	localparam logic [7:0] OP_RD_CAL = 8'h38;
	localparam logic [7:0] OP_WR_PAGE = 8'h4c;
	localparam logic [7:0] OP_EE_WR = 8'hc0;
	localparam logic [7:0] OP_EE_PAGE = 8'hc2;

	// ----------------------------------------
	// values after reset and erase
	// ----------------------------------------
	localparam logic [7:0] FUSE_LO_RST = 8'hff;
	localparam logic [7:0] FUSE_HI_RST = 8'hff;
	localparam logic [7:0] FUSE_EXT_RST = 8'hff;
	localparam logic [7:0] LOCK_RST = 8'hff;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [15:0] ERASED_WORD = 16'hffff;
	// identity values are arbitrary
	localparam logic [7:0] SIG_BYTE0 = 8'h5a;
	localparam logic [7:0] SIG_BYTE1 = 8'h01;
	localparam logic [7:0] SIG_BYTE2 = 8'h02;
	localparam logic [7:0] CAL_BYTE = 8'h80;

endpackage

// ---- pin_sync.sv ----
// Purpose: two-flop synchroniser for pins
// Assumes: inputs are asynchronous to clock
// Notes: first stage is read by the second stage only
`timescale 1ns/1ns
module pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// pins
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] pin_out
);

	logic [W-1:0] meta_r;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			meta_r <= INIT;
			pin_out <= INIT;
		end else begin
			meta_r <= pin_in;
			pin_out <= meta_r;
		end
	end

endmodule

// ---- op_timer.sv ----
// Purpose: self-timed wait counter for nonvolatile operations
// Assumes: start is a one-cycle pulse
// Notes: busy stays high for the loaded number of cycles
`timescale 1ns/1ns
module op_timer (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// control
	input wire logic start,
	input wire logic [isp_pkg::TIMER_W-1:0] cycles,
	output logic busy
);

	logic [isp_pkg::TIMER_W-1:0] cnt_r;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= '0;
		end else if (start) begin
			cnt_r <= cycles;
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end

	assign busy = (cnt_r != '0);

endmodule

// ---- serial_isp_command_engine_sva.sv ----
// Purpose: port checks of the serial programming engine
// Assumes: sck pin idles low between frames
// Notes: bound into every engine instance
`timescale 1ns/1ns
module isp_port_checker #(
	parameter int FLASH_WAIT_CYCLES = 100,
	parameter int EEPROM_WAIT_CYCLES = 100,
	parameter int ERASE_WAIT_CYCLES = 100,
	parameter int FUSE_WAIT_CYCLES = 100
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// pins
	input wire logic isp_reset_n,
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso,
	// status
	input wire logic prog_active,
	input wire logic prog_enabled,
	input wire logic operation_pending_flag,
	input wire logic core_run,
	input wire logic [7:0] ext_address
);
	localparam int MA = FLASH_WAIT_CYCLES < FUSE_WAIT_CYCLES ? FLASH_WAIT_CYCLES : FUSE_WAIT_CYCLES;
	localparam int MB = EEPROM_WAIT_CYCLES < ERASE_WAIT_CYCLES ? EEPROM_WAIT_CYCLES : ERASE_WAIT_CYCLES;
	localparam int PEND_MIN = MA < MB ? MA : MB;
	// ----------------------------------------
	// pin rise count and busy length
	// ----------------------------------------
	logic sck_q_r;
	logic [4:0] rise_cnt_r;
	logic [16:0] pend_len_r;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sck_q_r <= 1'b0;
			rise_cnt_r <= 5'h00;
			pend_len_r <= 17'h00000;
		end else begin
			sck_q_r <= sck;
			rise_cnt_r <= isp_reset_n ? 5'h00 : rise_cnt_r + {4'h0, sck & ~sck_q_r};
			pend_len_r <= operation_pending_flag ? pend_len_r + 17'h00001 : 17'h00000;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	AST_RUN_FLAG: assert property (core_run != prog_active)
		else $error("core_run is not the inverse of prog_active");
	AST_ENTER: assert property ($fell(isp_reset_n) |-> ##[1:4] prog_active)
		else $error("session not entered");
	AST_EXIT: assert property ($rose(isp_reset_n) |-> ##[1:5] !prog_active && !prog_enabled)
		else $error("session not left");
	AST_OFF_IDLE: assert property (!prog_active && !$past(prog_active) |-> !prog_enabled)
		else $error("enabled outside a session");
	AST_MISO_FALL: assert property ($changed(miso) |-> !$past(sck, 1) && !$past(sck, 2))
		else $error("miso moved while sck high");
	AST_PEND_START: assert property ($rose(operation_pending_flag) |-> prog_enabled && rise_cnt_r == 5'h00)
		else $error("busy started off a frame end or unenabled");
	AST_PEND_LEN: assert property ($fell(operation_pending_flag) |-> pend_len_r >= 17'(PEND_MIN - 1))
		else $error("busy too short");
	AST_ENABLE_FRAME: assert property ($rose(prog_enabled) |-> prog_active && rise_cnt_r == 5'h00)
		else $error("enable off a frame end");
	AST_EXT_FRAME: assert property ($changed(ext_address) |-> prog_enabled && rise_cnt_r == 5'h00)
		else $error("extended address moved off a frame end");
	AST_ENABLE_IN_SESSION: assert property (prog_enabled |-> prog_active)
		else $error("enabled while not in a session");
	cover property ($rose(prog_enabled));
	cover property (prog_enabled && rise_cnt_r == 5'h1f && mosi);
	cover property ($fell(operation_pending_flag));
	cover property ($changed(ext_address));
endmodule
bind serial_isp_command_engine isp_port_checker #(.FLASH_WAIT_CYCLES(FLASH_WAIT_CYCLES),
	.EEPROM_WAIT_CYCLES(EEPROM_WAIT_CYCLES), .ERASE_WAIT_CYCLES(ERASE_WAIT_CYCLES),
	.FUSE_WAIT_CYCLES(FUSE_WAIT_CYCLES)) isp_port_checker_i (.clock(clock), .reset_n(reset_n),
	.isp_reset_n(isp_reset_n), .sck(sck), .mosi(mosi), .miso(miso), .prog_active(prog_active),
	.prog_enabled(prog_enabled), .operation_pending_flag(operation_pending_flag),
	.core_run(core_run), .ext_address(ext_address));

// ---- isp_programmer_model.sv ----
// Purpose: programmer model on the serial programming pins
// Assumes: sck phase of four core clocks
// Notes: sck stands low and mosi flips between frames
`timescale 1ns/1ns
module isp_programmer_model #(
	parameter int START_WAIT = 40
) (
	// clock
	input wire logic clock,
	// pins
	output logic isp_reset_n,
	output logic sck,
	output logic mosi,
	input wire logic miso
);
	// power up with reset pin and sck low
	initial begin
		isp_reset_n = 1'b0;
		sck = 1'b0;
		mosi = 1'b0;
	end
	// pulse reset pin, then settle before the first frame
	task automatic open_session;
		@(posedge clock);
		isp_reset_n <= 1'b1;
		repeat (4) @(posedge clock);
		isp_reset_n <= 1'b0;
		repeat (START_WAIT) @(posedge clock);
	endtask
	task automatic close_session;
		@(posedge clock);
		isp_reset_n <= 1'b1;
		repeat (8) @(posedge clock);
	endtask
	// msb first, mosi set while sck low, miso taken at the rise
	task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
		@(posedge clock);
		for (int i = 31; i >= 0; i--) begin
			mosi <= tx[i];
			repeat (4) @(posedge clock);
			rx[i] = miso;
			sck <= 1'b1;
			repeat (4) @(posedge clock);
			sck <= 1'b0;
		end
		mosi <= ~tx[0];
	endtask
	task automatic enable(output logic [31:0] rx);
		for (int n = 0; n < 3; n++) begin
			xfer(32'hac530000, rx);
			if (rx[15:8] == 8'h53)
				break;
			open_session();
		end
	endtask
	task automatic poll(output int n);
		logic [31:0] rx;
		n = 0;
		do begin
			xfer(32'hf0000000, rx);
			n++;
		end while (rx[0] !== 1'b0 && n < 64);
	endtask
endmodule

// ---- serial_isp_command_engine_bench.sv ----
// Purpose: self-checking bench of the serial programming engine
// Assumes: programmer model drives the pins
// Notes: wait counts shortened
`timescale 1ns/1ns
module serial_isp_command_engine_bench;
	logic clock;
	logic reset_n;
	logic isp_reset_n;
	logic sck;
	logic mosi;
	logic miso;
	logic prog_active;
	logic prog_enabled;
	logic operation_pending_flag;
	logic core_run;
	logic [7:0] ext_address;
	logic [31:0] rx;
	int err_total;
	int total_checks;
	int n;
	logic [31:0] rd_f [4] = '{32'h50000000, 32'h58080000, 32'h50080000, 32'h58000000};
	logic [7:0] wr_s [4] = '{8'ha0, 8'ha8, 8'ha4, 8'he0};
	logic [7:0] val [4] = '{8'he2, 8'hd9, 8'hfe, 8'hfc};
	serial_isp_command_engine #(.FLASH_WAIT_CYCLES(400), .EEPROM_WAIT_CYCLES(500),
		.ERASE_WAIT_CYCLES(600), .FUSE_WAIT_CYCLES(450)) serial_isp_command_engine_i (
		.clock(clock), .reset_n(reset_n), .isp_reset_n(isp_reset_n), .sck(sck), .mosi(mosi),
		.miso(miso), .prog_active(prog_active), .prog_enabled(prog_enabled),
		.operation_pending_flag(operation_pending_flag), .core_run(core_run),
		.ext_address(ext_address));
	isp_programmer_model isp_programmer_model_i (.clock(clock), .isp_reset_n(isp_reset_n),
		.sck(sck), .mosi(mosi), .miso(miso));
	initial clock = 1'b0;
	always #50 clock = ~clock;
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic cmd(input logic [31:0] f);
		isp_programmer_model_i.xfer(f, rx);
	endtask
	task automatic rd(input logic [31:0] f, input logic [7:0] exp, input string what);
		cmd(f);
		check(rx[7:0], exp, what);
	endtask
	// order: active, run, enabled, pending
	task automatic flags(input logic [3:0] exp, input string what);
		repeat (4) @(negedge clock);
		check({4'h0, prog_active, core_run, prog_enabled, operation_pending_flag}, {4'h0, exp}, what);
	endtask
	task automatic wait_done(input string what);
		isp_programmer_model_i.poll(n);
		check({7'h00, n > 1 && n < 64}, 8'h01, what);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_open;
		isp_programmer_model_i.open_session();
		flags(4'b1000, "session entry");
		rd(32'h58000000, 8'h00, "read before enable");
		cmd(32'haca00000);
		flags(4'b1000, "write before enable");
		$display("test open done");
	endtask
	task automatic t_enable;
		isp_programmer_model_i.enable(rx);
		check(rx[15:8], 8'h53, "enable echo");
		flags(4'b1010, "enabled");
		$display("test enable done");
	endtask
	task automatic t_fuse;
		for (int i = 0; i < 4; i++) begin
			rd(rd_f[i], 8'hff, "fuse default");
			cmd({8'hac, wr_s[i], 8'h00, val[i]});
			wait_done("fuse busy");
			rd(rd_f[i], val[i], "fuse readback");
		end
		$display("test fuse done");
	endtask
	task automatic t_flash;
		// first commit turns the never-loaded buffer into erased words
		cmd(32'h4c000000);
		wait_done("buffer prime");
		cmd(32'h40003f33);
		cmd(32'h48003f44);
		cmd(32'h40000511);
		cmd(32'h48000522);
		cmd(32'h4c1fc000);
		wait_done("page busy");
		rd(32'h201fc500, 8'h11, "flash low");
		rd(32'h281fc500, 8'h22, "flash high");
		rd(32'h201fff00, 8'h33, "flash top low");
		rd(32'h281fff00, 8'h44, "flash top high");
		rd(32'h281fc600, 8'hff, "unloaded word");
		$display("test flash done");
	endtask
	task automatic t_eeprom;
		cmd(32'hc001ff5a);
		wait_done("eeprom busy");
		rd(32'ha001ff00, 8'h5a, "eeprom byte");
		for (int i = 0; i < 4; i++) begin
			cmd({16'hc001, 8'(i), 8'h10 + 8'(i)});
			wait_done("eeprom fill");
		end
		cmd(32'hc10001a1);
		cmd(32'hc10003a3);
		cmd(32'hc2010000);
		wait_done("eeprom page busy");
		for (int i = 0; i < 4; i++)
			rd({16'ha001, 8'(i), 8'h00}, 8'(i % 2 ? 8'ha0 + i : 8'h10 + i), "eeprom page");
		$display("test eeprom done");
	endtask
	task automatic t_ext;
		cmd(32'h4d00a500);
		repeat (4) @(negedge clock);
		check(ext_address, 8'ha5, "ext address");
		rd(32'h30000000, isp_pkg::SIG_BYTE0, "signature 0");
		rd(32'h30000200, isp_pkg::SIG_BYTE2, "signature 2");
		rd(32'h38000000, isp_pkg::CAL_BYTE, "calibration");
		$display("test ext done");
	endtask
	task automatic t_erase;
		cmd(32'hac800000);
		wait_done("erase busy");
		rd(32'h201fc500, 8'hff, "erased flash");
		rd(32'h281fff00, 8'hff, "erased flash high");
		rd(32'ha001ff00, 8'hff, "erased eeprom");
		$display("test erase done");
	endtask
	task automatic t_exit;
		isp_programmer_model_i.close_session();
		flags(4'b0100, "session left");
		t_open();
		$display("test exit done");
	endtask
	initial begin
		reset_n = 1'b0;
		err_total = 0;
		total_checks = 0;
		repeat (20) @(posedge clock);
		reset_n <= 1'b1;
		t_open();
		t_enable();
		t_fuse();
		t_flash();
		t_eeprom();
		t_ext();
		t_erase();
		t_exit();
		wrap_up();
	end
	initial begin
		repeat (60000) @(posedge clock);
		err_total++;
		$display("wrong value at %0t: watchdog expired", $time);
		wrap_up();
	end
endmodule
